// *** hw/rtat_top.sv ***
// Remote target address table for entries 2 to 6 with alias remapping.
`timescale 1ns/100ps
`default_nettype none
`include "rtat_cfg.svh"

// ==========================================================================
// ==========================================================================

module rtat_top
  import rtat_pkg::*;
(
  // Clock and reset.
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,

  // Register port.
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wr_data,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  output logic [7:0]       o_rd_data,

  // Alias values from the alias registers.
  input  wire logic [6:0]  i_local_alias_field_2,
  input  wire logic [6:0]  i_local_alias_field_3,
  input  wire logic [6:0]  i_local_alias_field_4,
  input  wire logic [6:0]  i_local_alias_field_5,
  input  wire logic [6:0]  i_local_alias_field_6,

  // Local I2C target port request.
  input  wire logic        i_txn_valid,
  input  wire logic [6:0]  i_txn_addr,
  input  wire logic        i_txn_rnw,
  output logic             o_txn_ack,
  output logic             o_txn_block,

  // Control channel forwarder request.
  output logic             o_fwd_valid,
  output logic [6:0]       o_fwd_addr,
  output logic             o_fwd_rnw,
  output logic [2:0]       o_fwd_entry,

  // Stored target addresses.
  output logic [6:0]       o_target_addr_field_2,
  output logic [6:0]       o_target_addr_field_3,
  output logic [6:0]       o_target_addr_field_4,
  output logic [6:0]       o_target_addr_field_5,
  output logic [6:0]       o_target_addr_field_6
);

  // ========================================================================
  // Decode helpers
  // ========================================================================
  function automatic logic is_entry_addr(input logic [7:0] addr);
    return (addr >= `RTAT_ADDR_ENTRY_2) && (addr <= `RTAT_ADDR_ENTRY_6);
  endfunction

  function automatic rtat_index_t entry_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - `RTAT_ADDR_ENTRY_2;
    return diff[2:0];
  endfunction

  // ========================================================================
  // State
  // ========================================================================
  rtat_state_t                       s_q;
  rtat_state_t                       s_d;
  logic [`RTAT_NUM_ENTRIES-1:0][6:0] alias_vec;
  logic                              alias_hit;
  rtat_index_t                       hit_index;
  rtat_addr7_t                       hit_entry;

  assign alias_vec = {i_local_alias_field_6, i_local_alias_field_5,
                      i_local_alias_field_4, i_local_alias_field_3,
                      i_local_alias_field_2};

  // ========================================================================
  // Alias match
  // ========================================================================
  rtat_match #(
    .N  (`RTAT_NUM_ENTRIES),
    .W  (7),
    .IW (3)
  ) u_match (
    .i_alias (alias_vec),
    .i_addr  (i_txn_addr),
    .o_hit   (alias_hit),
    .o_index (hit_index)
  );

  // The entry value in force in the request cycle is the one used.
  assign hit_entry = s_q.entry[hit_index];

  // ========================================================================
  // Next state
  // ========================================================================
  always_comb begin
    s_d           = s_q;
    s_d.rd_data   = `RTAT_RD_IDLE;
    s_d.fwd_valid = 1'b0;
    s_d.txn_ack   = 1'b0;
    s_d.txn_block = 1'b0;

    // Register writes store bits 7 to 1; bit 0 is dropped.
    if (i_wr_en) begin
      if (is_entry_addr(i_addr)) begin
        s_d.entry[entry_index(i_addr)] =
          i_wr_data[`RTAT_FIELD_MSB:`RTAT_FIELD_LSB];
      end
    end

    // Read data stand for exactly the cycle after the strobe.
    if (i_rd_en) begin
      if (is_entry_addr(i_addr)) begin
        s_d.rd_data = {s_q.entry[entry_index(i_addr)], 1'b0};
      end else if (i_addr == `RTAT_ADDR_STATUS) begin
        s_d.rd_data = {2'h0, s_q.last_outcome, s_q.last_entry};
      end else begin
        s_d.rd_data = `RTAT_RD_IDLE;
      end
    end

    // Transactions to a nonzero alias are ours; the entry decides the rest.
    if (i_txn_valid && alias_hit) begin
      s_d.last_entry = 3'(hit_index + `RTAT_FIRST_ENTRY);
      if (hit_entry != `RTAT_ENTRY_RESET) begin
        s_d.fwd_valid    = 1'b1;
        s_d.fwd_addr     = hit_entry;
        s_d.fwd_rnw      = i_txn_rnw;
        s_d.fwd_entry    = 3'(hit_index + `RTAT_FIRST_ENTRY);
        s_d.txn_ack      = 1'b1;
        s_d.last_outcome = RTAT_OUT_FWD;
      end else begin
        s_d.txn_block    = 1'b1;
        s_d.last_outcome = RTAT_OUT_BLOCK;
      end
    end
  end

  // ========================================================================
  // Registers
  // ========================================================================
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      s_q              <= '0;
      s_q.last_outcome <= RTAT_OUT_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  assign o_rd_data             = s_q.rd_data;
  assign o_txn_ack             = s_q.txn_ack;
  assign o_txn_block           = s_q.txn_block;
  assign o_fwd_valid           = s_q.fwd_valid;
  assign o_fwd_addr            = s_q.fwd_addr;
  assign o_fwd_rnw             = s_q.fwd_rnw;
  assign o_fwd_entry           = s_q.fwd_entry;
  assign o_target_addr_field_2 = s_q.entry[0];
  assign o_target_addr_field_3 = s_q.entry[1];
  assign o_target_addr_field_4 = s_q.entry[2];
  assign o_target_addr_field_5 = s_q.entry[3];
  assign o_target_addr_field_6 = s_q.entry[4];

  // ========================================================================
  // Checks
  // ========================================================================
  entry_write_a: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (i_wr_en && is_entry_addr(i_addr))
      |=> (s_q.entry[entry_index($past(i_addr))] == $past(i_wr_data[7:1]))
  ) else $error("entry write not stored");

  write_readback_a: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    ((i_wr_en && is_entry_addr(i_addr))
      ##1 (i_rd_en && !i_wr_en && (i_addr == $past(i_addr))))
      |=> (o_rd_data == {$past(i_wr_data[7:1], 2), 1'b0})
  ) else $error("entry read back differs from write");

  remap_forward_a: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (i_txn_valid && alias_hit && (hit_entry != 7'h00))
      |=> (o_fwd_valid && o_txn_ack && (o_fwd_addr == $past(hit_entry))
           && (o_fwd_rnw == $past(i_txn_rnw))
           && (o_fwd_entry == $past(hit_index) + 3'h2))
  ) else $error("aliased transaction not remapped and forwarded");

  zero_blocks_a: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (i_txn_valid && alias_hit && (hit_entry == 7'h00))
      |=> (!o_fwd_valid && !o_txn_ack && o_txn_block)
  ) else $error("zero entry did not block transaction");

  fwd_cause_a: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    o_fwd_valid |-> ($past(i_txn_valid) && ($past(i_txn_addr) != 7'h00)
                     && (o_fwd_addr != 7'h00))
  ) else $error("forward without nonzero alias request");

  miss_ignored_a: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (!alias_hit || !i_txn_valid)
      |=> (!o_fwd_valid && !o_txn_ack && !o_txn_block)
  ) else $error("transaction taken without alias hit");

  reserved_zero_a: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    $past(i_rd_en) && is_entry_addr($past(i_addr)) |-> (o_rd_data[0] == 1'b0)
  ) else $error("reserved bit read as one");

  reset_clear_a: assert property (
    @(posedge i_core_clk)
    ($past(i_reset) && !i_reset)
      |-> ((s_q.entry == '0) && !o_fwd_valid && (o_rd_data == 8'h00))
  ) else $error("table not cleared by reset");

  rd_window_a: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    !i_rd_en |=> (o_rd_data == 8'h00)
  ) else $error("read data outside read window");

endmodule

`default_nettype wire

// *** common/rtat_cfg.svh ***
// Offsets, field positions, reset values and sizes of the remote target address table.
`ifndef RTAT_CFG_SVH
`define RTAT_CFG_SVH

// ==========================================================================
// Register offsets
// ==========================================================================
`define RTAT_ADDR_ENTRY_2   8'h0a
`define RTAT_ADDR_ENTRY_3   8'h0b
`define RTAT_ADDR_ENTRY_4   8'h0c
`define RTAT_ADDR_ENTRY_5   8'h0d
`define RTAT_ADDR_ENTRY_6   8'h0e
`define RTAT_ADDR_STATUS    8'h20

// ==========================================================================
// Field layout and reset values
// ==========================================================================
`define RTAT_FIELD_MSB      7
`define RTAT_FIELD_LSB      1
`define RTAT_RESERVED_BIT   0
`define RTAT_ENTRY_RESET    7'h00
`define RTAT_RD_IDLE        8'h00

// ==========================================================================
// Table size
// ==========================================================================
`define RTAT_NUM_ENTRIES    5
`define RTAT_FIRST_ENTRY    3'h2

`endif

// *** common/rtat_pkg.sv ***
// Types shared by the remote target address table modules.
`include "rtat_cfg.svh"

package rtat_pkg;

  // ========================================================================
  // Basic types
  // ========================================================================
  typedef logic [6:0] rtat_addr7_t;
  typedef logic [2:0] rtat_index_t;

  // Outcome of the most recent alias hit, one-hot.
  typedef enum logic [2:0] {
    RTAT_OUT_NONE  = 3'b001,
    RTAT_OUT_FWD   = 3'b010,
    RTAT_OUT_BLOCK = 3'b100
  } rtat_outcome_t;

  // ========================================================================
  // Complete state of the table
  // ========================================================================
  typedef struct packed {
    logic [`RTAT_NUM_ENTRIES-1:0][6:0] entry;
    logic [7:0]                        rd_data;
    logic                              fwd_valid;
    rtat_addr7_t                       fwd_addr;
    logic                              fwd_rnw;
    rtat_index_t                       fwd_entry;
    logic                              txn_ack;
    logic                              txn_block;
    rtat_index_t                       last_entry;
    rtat_outcome_t                     last_outcome;
  } rtat_state_t;

endpackage

// *** hw/rtat_match.sv ***
// Alias comparator that finds the table entry a local bus address belongs to.
`timescale 1ns/100ps
`default_nettype none

module rtat_match #(
  parameter int N  = 5,
  parameter int W  = 7,
  parameter int IW = 3
) (
  // Alias values, one per entry.
  input  wire logic [N-1:0][W-1:0] i_alias,
  // Address of the local transaction.
  input  wire logic [W-1:0]        i_addr,
  // Match result.
  output logic                     o_hit,
  output logic [IW-1:0]            o_index
);

  // A zero alias never matches; the lowest entry wins if several match.
  always_comb begin
    o_hit   = 1'b0;
    o_index = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if ((i_alias[k] != '0) && (i_alias[k] == i_addr)) begin
        o_hit   = 1'b1;
        o_index = IW'(k);
      end
    end
  end

endmodule

`default_nettype wire

// *** dv/rtat_host_model.sv ***
// Local bus host model that issues address phases to the table.
`timescale 1ns/100ps
`default_nettype none

module rtat_host_model (
  // Clock.
  input  wire logic  i_core_clk,
  // Address phase towards the table.
  output logic       o_txn_valid,
  output logic [6:0] o_txn_addr,
  output logic       o_txn_rnw
);
  initial begin
    o_txn_valid = 1'b0;
    o_txn_addr  = 7'h55;
    o_txn_rnw   = 1'b0;
  end

  // Outside the address phase the lines carry the inverse of the last value.
  task automatic send(input logic [6:0] a, input logic rnw);
    @(posedge i_core_clk);
    o_txn_valid <= 1'b1;
    o_txn_addr  <= a;
    o_txn_rnw   <= rnw;
    @(posedge i_core_clk);
    o_txn_valid <= 1'b0;
    o_txn_addr  <= ~a;
    o_txn_rnw   <= ~rnw;
  endtask
endmodule
`default_nettype wire

// *** dv/rtat_top_tb.sv ***
// Self-checking testbench of the remote target address table.
`timescale 1ns/100ps
`default_nettype none

module rtat_top_tb;
  logic       i_core_clk = 1'b0;
  logic       i_reset    = 1'b1;
  logic [7:0] i_addr     = 8'h00;
  logic [7:0] i_wr_data  = 8'h00;
  logic       i_wr_en    = 1'b0;
  logic       i_rd_en    = 1'b0;
  logic [6:0] al [5]     = '{7'h00, 7'h00, 7'h00, 7'h00, 7'h00};
  wire  logic [7:0] o_rd_data;
  wire  logic       tv, trnw, o_txn_ack, o_txn_block, o_fwd_valid, o_fwd_rnw;
  wire  logic [6:0] ta, o_fwd_addr;
  wire  logic [2:0] o_fwd_entry;
  wire  logic [6:0] tgt [5];
  int         err_total = 0;
  int         n_tests   = 0;
  logic [7:0] rd, wd;

  always #12.5 i_core_clk = ~i_core_clk;

  rtat_host_model i_rtat_host_model (.i_core_clk(i_core_clk), .o_txn_valid(tv),
    .o_txn_addr(ta), .o_txn_rnw(trnw));

  rtat_top i_rtat_top (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
    .i_local_alias_field_2(al[0]), .i_local_alias_field_3(al[1]),
    .i_local_alias_field_4(al[2]), .i_local_alias_field_5(al[3]),
    .i_local_alias_field_6(al[4]), .i_txn_valid(tv), .i_txn_addr(ta), .i_txn_rnw(trnw),
    .o_txn_ack(o_txn_ack), .o_txn_block(o_txn_block), .o_fwd_valid(o_fwd_valid),
    .o_fwd_addr(o_fwd_addr), .o_fwd_rnw(o_fwd_rnw), .o_fwd_entry(o_fwd_entry),
    .o_target_addr_field_2(tgt[0]), .o_target_addr_field_3(tgt[1]),
    .o_target_addr_field_4(tgt[2]), .o_target_addr_field_5(tgt[3]),
    .o_target_addr_field_6(tgt[4]));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_addr    <= a;
    i_wr_data <= d;
    i_wr_en   <= 1'b1;
    @(posedge i_core_clk);
    i_wr_en   <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rdx(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_core_clk);
    i_addr  <= a;
    i_rd_en <= 1'b1;
    @(posedge i_core_clk);
    i_rd_en <= 1'b0;
    #1;
    chk(o_rd_data, exp);
  endtask

  // Write, then read the same address in the very next cycle.
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge i_core_clk);
    i_addr    <= a;
    i_wr_data <= d;
    i_wr_en   <= 1'b1;
    @(posedge i_core_clk);
    i_wr_en   <= 1'b0;
    i_rd_en   <= 1'b1;
    @(posedge i_core_clk);
    i_rd_en   <= 1'b0;
    #1;
    chk(o_rd_data, exp);
  endtask

  // Sends one address phase and checks the pulses and the forward fields.
  task automatic txn(input logic [6:0] a, input logic rnw, input logic [2:0] fl,
                     input logic [6:0] fa, input logic [2:0] fe, input logic fr);
    i_rtat_host_model.send(a, rnw);
    #1;
    chk({5'h00, o_fwd_valid, o_txn_ack, o_txn_block}, {5'h00, fl});
    chk({1'b0, o_fwd_addr}, {1'b0, fa});
    chk({4'h0, o_fwd_rnw, o_fwd_entry}, {4'h0, fr, fe});
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    err_total++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge i_core_clk);
    i_reset <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rdx(8'h0a + 8'(i), 8'h00);
    end
    rdx(8'h20, 8'h08);
    $display("test reset values done");
    for (int i = 0; i < 5; i++) begin
      wd = 8'h23 + 8'(i * 34);
      wr(8'h0a + 8'(i), wd);
      rdx(8'h0a + 8'(i), wd & 8'hfe);
      chk({1'b0, tgt[i]}, {1'b0, wd[7:1]});
      @(posedge i_core_clk);
      al[i] <= 7'h40 + 7'(i);
    end
    wr_rd(8'h0a, 8'h23, 8'h22);
    wr(8'h30, 8'hff);
    rdx(8'h30, 8'h00);
    $display("test register access done");
    for (int i = 0; i < 5; i++) begin
      wd = 8'h23 + 8'(i * 34);
      txn(7'h40 + 7'(i), i[0], 3'b110, wd[7:1], 3'h2 + 3'(i), i[0]);
    end
    $display("test remapping done");
    @(posedge i_core_clk);
    al[4] <= 7'h00;
    txn(7'h00, 1'b1, 3'b000, wd[7:1], 3'h6, 1'b0);
    txn(7'h7f, 1'b1, 3'b000, wd[7:1], 3'h6, 1'b0);
    wr(8'h0c, 8'h01);
    rdx(8'h0c, 8'h00);
    txn(7'h42, 1'b1, 3'b001, wd[7:1], 3'h6, 1'b0);
    rdx(8'h20, 8'h24);
    @(posedge i_core_clk);
    al[3] <= 7'h41;
    txn(7'h41, 1'b0, 3'b110, 7'h22, 3'h3, 1'b0);
    rdx(8'h20, 8'h13);
    $display("test blocking done");
    @(posedge i_core_clk);
    i_reset <= 1'b1;
    @(posedge i_core_clk);
    i_reset <= 1'b0;
    rdx(8'h0a, 8'h00);
    txn(7'h40, 1'b0, 3'b001, 7'h00, 3'h0, 1'b0);
    $display("test second reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
